// >>> shared/bdfm_pkg.sv
package bdfm_pkg;

  localparam int CLK_MHZ = 250;

  // short filter window 2.5 .. 4.5 us, chosen 3.5 us (in ns)
  localparam int SC_FILT_NS = 3500;
  localparam int SC_FILT_CYC = (SC_FILT_NS * CLK_MHZ) / 1000;
  // enable low to stages off, at most 3.0 us
  localparam int ENA_OFF_NS = 3000;
  localparam int ENA_OFF_CYC = (ENA_OFF_NS * CLK_MHZ) / 1000;
  // enable low pulses up to 1.2 us are ignored for clearing
  localparam int RST0_NS = 1200;
  localparam int RST0_CYC = (RST0_NS * CLK_MHZ + 999) / 1000;
  // enable high time before error logic active, 4 .. 7 us, chosen 5.5 us
  localparam int RST1_NS = 5500;
  localparam int RST1_CYC = (RST1_NS * CLK_MHZ) / 1000;
  // low-side gates forced high within 100 us of start-up, chosen 50 us
  localparam int GL_START_NS = 50000;
  localparam int GL_START_CYC = (GL_START_NS * CLK_MHZ) / 1000;
  // supply filters
  localparam int OV_FILT_NS = 1000;
  localparam int OV_FILT_CYC = (OV_FILT_NS * CLK_MHZ) / 1000;
  localparam int UV_FILT_NS = 1000;
  localparam int UV_FILT_CYC = (UV_FILT_NS * CLK_MHZ) / 1000;

  typedef enum logic [2:0] {
    BDFM_SLEEP   = 3'b000,
    BDFM_START   = 3'b001,
    BDFM_NORMAL  = 3'b010,
    BDFM_SC_ERR  = 3'b011,
    BDFM_UV_OFF  = 3'b100
  } bdfm_mode_type;

endpackage

// >>> core/bdfm_fault_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module bdfm_fault_monitor
  import bdfm_pkg::*;
#(
  parameter int PHASES      = 2,
  parameter int DT_CYC      = 100,
  parameter int BLANK_CYC   = 250,
  parameter int GL_START    = GL_START_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              run_input_i,
  input  wire logic [PHASES-1:0] hs_cmd_i,
  input  wire logic [PHASES-1:0] ls_cmd_i,
  input  wire logic [PHASES-1:0] hs_over_level_i,
  input  wire logic [PHASES-1:0] ls_over_level_i,
  input  wire logic              short_level_pin_open_i,
  input  wire logic              supply_over_i,
  input  wire logic              drain_high_sense_over_i,
  input  wire logic              supply_under_i,
  output logic [PHASES-1:0]      hs_gate_o,
  output logic [PHASES-1:0]      low_side_gate_out_o,
  output logic                   fault_n_o,
  output logic                   supply_low_lockout_o,
  output logic                   regulator_en_o
);

  localparam int CW = 16;
  localparam int GW = $clog2(GL_START + 1) + 1;

  initial begin
    if (PHASES < 1 || DT_CYC < 1 || BLANK_CYC < 1 || GL_START < 1 || GL_START >= 2**GW)
      $error("bdfm_fault_monitor: bad parameter");
    if (DT_CYC + BLANK_CYC >= 2**CW)
      $error("bdfm_fault_monitor: timing too long");
    if (RST0_CYC >= ENA_OFF_CYC || RST0_CYC >= RST1_CYC)
      $error("bdfm_fault_monitor: enable timing inconsistent");
    if (SC_FILT_CYC < 1 || SC_FILT_CYC >= 2**CW || RST1_CYC >= 2**CW)
      $error("bdfm_fault_monitor: short filter or arm time too long");
    if (ENA_OFF_CYC < 2 || ENA_OFF_CYC >= 2**CW)
      $error("bdfm_fault_monitor: enable off time out of range");
    if (OV_FILT_CYC >= 2**CW || UV_FILT_CYC >= 2**CW)
      $error("bdfm_fault_monitor: supply filter too long");
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable pin timing

  logic [CW-1:0] low_cnt_q, low_cnt_d;
  logic [CW-1:0] high_cnt_q, high_cnt_d;
  logic          clr_pend_q, clr_pend_d;
  logic          run_q, run_d;
  logic          ena_off;
  logic          err_active;

  always_comb begin
    run_d      = run_input_i;
    low_cnt_d  = low_cnt_q;
    high_cnt_d = high_cnt_q;
    clr_pend_d = clr_pend_q;
    if (!run_input_i) begin
      high_cnt_d = '0;
      if (low_cnt_q != CW'(ENA_OFF_CYC))
        low_cnt_d = low_cnt_q + CW'(1);
      if (low_cnt_q >= CW'(RST0_CYC))
        clr_pend_d = 1'b1;
    end else begin
      low_cnt_d = '0;
      if (high_cnt_q != CW'(RST1_CYC))
        high_cnt_d = high_cnt_q + CW'(1);
      if (!run_q)
        clr_pend_d = 1'b0;
    end
  end

  // one cycle early so the registered gates meet the limit
  assign ena_off    = !run_input_i && (low_cnt_q >= CW'(ENA_OFF_CYC - 1));
  assign err_active = run_input_i && (high_cnt_q == CW'(RST1_CYC));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt_q  <= '0;
      high_cnt_q <= '0;
      clr_pend_q <= 1'b0;
      run_q      <= 1'b0;
    end else begin
      low_cnt_q  <= low_cnt_d;
      high_cnt_q <= high_cnt_d;
      clr_pend_q <= clr_pend_d;
      run_q      <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per phase dead time, blanking and shared short filter

  logic [PHASES-1:0] sc_hit;
  logic              outputs_on;

  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_ph
      logic [CW-1:0] hs_t_q, hs_t_d, ls_t_q, ls_t_d;
      logic [CW-1:0] filt_q, filt_d;
      logic          hs_eval, ls_eval, up, on;

      always_comb begin
        hs_t_d = '0;
        ls_t_d = '0;
        if (hs_gate_o[p] && hs_t_q != CW'(DT_CYC + BLANK_CYC))
          hs_t_d = hs_t_q + CW'(1);
        else if (hs_gate_o[p])
          hs_t_d = hs_t_q;
        if (low_side_gate_out_o[p] && ls_t_q != CW'(DT_CYC + BLANK_CYC))
          ls_t_d = ls_t_q + CW'(1);
        else if (low_side_gate_out_o[p])
          ls_t_d = ls_t_q;
        hs_eval = hs_gate_o[p] && hs_t_q == CW'(DT_CYC + BLANK_CYC);
        ls_eval = low_side_gate_out_o[p] && ls_t_q == CW'(DT_CYC + BLANK_CYC);
        up      = (hs_eval && hs_over_level_i[p]) || (ls_eval && ls_over_level_i[p]);
        on      = hs_gate_o[p] || low_side_gate_out_o[p];
        // holds while the error logic is still arming
        filt_d  = filt_q;
        if (up && err_active && filt_q != CW'(SC_FILT_CYC))
          filt_d = filt_q + CW'(1);
        else if ((!up || !on) && filt_q != '0)
          filt_d = filt_q - CW'(1);
      end

      assign sc_hit[p] = (filt_q == CW'(SC_FILT_CYC));

      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          hs_t_q <= '0;
          ls_t_q <= '0;
          filt_q <= '0;
        end else begin
          hs_t_q <= hs_t_d;
          ls_t_q <= ls_t_d;
          filt_q <= filt_d;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mode control and supply filters

  bdfm_mode_type mode_q, mode_d;
  logic [CW-1:0] ov_cnt_q, ov_cnt_d;
  logic [CW-1:0] uv_cnt_q, uv_cnt_d;
  logic [GW-1:0] st_cnt_q, st_cnt_d;
  logic          ov_warn_q, ov_warn_d;
  logic          gl_auto_q, gl_auto_d;
  logic          sc_keep_q, sc_keep_d;
  logic          uv_hit, sc_any;

  assign sc_any = |sc_hit;
  assign uv_hit = (uv_cnt_q == CW'(UV_FILT_CYC));

  always_comb begin
    mode_d    = mode_q;
    st_cnt_d  = st_cnt_q;
    gl_auto_d = gl_auto_q;
    ov_cnt_d  = '0;
    uv_cnt_d  = '0;
    ov_warn_d = ov_warn_q;
    sc_keep_d = sc_keep_q;
    // warning only, the stages keep driving
    if (supply_over_i || drain_high_sense_over_i) begin
      ov_cnt_d = (ov_cnt_q == CW'(OV_FILT_CYC)) ? ov_cnt_q : ov_cnt_q + CW'(1);
      if (ov_cnt_q == CW'(OV_FILT_CYC))
        ov_warn_d = 1'b1;
    end else begin
      ov_warn_d = 1'b0;
    end
    if (supply_under_i)
      uv_cnt_d = uv_hit ? uv_cnt_q : uv_cnt_q + CW'(1);
    case (mode_q)
      BDFM_SLEEP: begin
        if (run_input_i && !run_q) begin
          mode_d    = BDFM_START;
          st_cnt_d  = '0;
          gl_auto_d = 1'b0;
        end
      end
      BDFM_START: begin
        if (st_cnt_q == GW'(GL_START)) begin
          gl_auto_d = 1'b1;
          mode_d    = BDFM_NORMAL;
        end else begin
          st_cnt_d = st_cnt_q + GW'(1);
        end
      end
      BDFM_NORMAL: begin
        if (sc_any)
          mode_d = BDFM_SC_ERR;
      end
      BDFM_SC_ERR: begin
        if (clr_pend_q)
          mode_d = BDFM_NORMAL;
      end
      BDFM_UV_OFF: begin
        if (run_input_i && !run_q && !supply_under_i)
          mode_d = BDFM_START;
        st_cnt_d = '0;
      end
      default: mode_d = BDFM_SLEEP;
    endcase
    if (uv_hit) begin
      mode_d    = BDFM_UV_OFF;
      gl_auto_d = 1'b0;
    end
    if (!run_input_i)
      gl_auto_d = 1'b0;
    // short survives undervoltage; only an enable reset clears it
    if (sc_any)
      sc_keep_d = 1'b1;
    else if (clr_pend_q)
      sc_keep_d = 1'b0;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q    <= BDFM_SLEEP;
      ov_cnt_q  <= '0;
      uv_cnt_q  <= '0;
      st_cnt_q  <= '0;
      ov_warn_q <= 1'b0;
      gl_auto_q <= 1'b0;
      sc_keep_q <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      ov_cnt_q  <= ov_cnt_d;
      uv_cnt_q  <= uv_cnt_d;
      st_cnt_q  <= st_cnt_d;
      ov_warn_q <= ov_warn_d;
      gl_auto_q <= gl_auto_d;
      sc_keep_q <= sc_keep_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic                sc_latched;
  logic [PHASES-1:0]   hs_d, ls_d;
  logic                fault_n_d;

  assign sc_latched = (mode_q == BDFM_SC_ERR) || sc_any || sc_keep_q;
  assign outputs_on = (mode_q == BDFM_NORMAL) && !sc_latched
                      && !short_level_pin_open_i && !ena_off;

  always_comb begin
    hs_d = outputs_on ? hs_cmd_i : '0;
    ls_d = outputs_on ? (ls_cmd_i | (gl_auto_q ? ~hs_cmd_i : '0)) : '0;
    fault_n_d = !(sc_latched || short_level_pin_open_i || ov_warn_q
                  || mode_q == BDFM_UV_OFF || mode_q != BDFM_NORMAL
                  || !run_input_i);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hs_gate_o            <= '0;
      low_side_gate_out_o  <= '0;
      fault_n_o            <= 1'b0;
      supply_low_lockout_o <= 1'b0;
      regulator_en_o       <= 1'b0;
    end else begin
      hs_gate_o            <= hs_d;
      low_side_gate_out_o  <= ls_d;
      fault_n_o            <= fault_n_d;
      // lockout and regulator follow next mode, a cycle ahead of fault
      supply_low_lockout_o <= (mode_d == BDFM_UV_OFF);
      regulator_en_o       <= (mode_d != BDFM_UV_OFF) && (mode_d != BDFM_SLEEP);
    end
  end

endmodule

`default_nettype wire

// >>> verif/bdfm_fault_monitor_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module bdfm_fault_monitor_chk
  import bdfm_pkg::*;
#(parameter int PHASES = 2) (
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              run_input_i,
  input wire logic              short_level_pin_open_i,
  input wire logic              supply_over_i,
  input wire logic              drain_high_sense_over_i,
  input wire logic              supply_under_i,
  input wire logic [PHASES-1:0] hs_gate_o,
  input wire logic [PHASES-1:0] low_side_gate_out_o,
  input wire logic              fault_n_o,
  input wire logic              supply_low_lockout_o,
  input wire logic              regulator_en_o
);
  logic [11:0] low_q, low_d, ov_q, ov_d, uv_q, uv_d;
  wire logic [PHASES-1:0] gates_any = hs_gate_o | low_side_gate_out_o;
  // saturating run lengths of each cause
  always_comb begin
    low_d = run_input_i ? 12'h000 : low_q + {11'h000, low_q != 12'hfff};
    ov_d = (supply_over_i | drain_high_sense_over_i) ? ov_q + {11'h000, ov_q != 12'hfff} : 12'h000;
    uv_d = supply_under_i ? uv_q + {11'h000, uv_q != 12'hfff} : 12'h000;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_q <= 12'h000;
      ov_q  <= 12'h000;
      uv_q  <= 12'h000;
    end else begin
      low_q <= low_d;
      ov_q  <= ov_d;
      uv_q  <= uv_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_lockout_fault: assert property (supply_low_lockout_o |=> !fault_n_o)
    else $error("lockout without fault");
  a_lockout_gates: assert property (supply_low_lockout_o |=> gates_any == '0)
    else $error("gate on in lockout");
  a_lockout_reg: assert property (supply_low_lockout_o |-> !regulator_en_o)
    else $error("regulator on in lockout");
  a_open_pin_off: assert property (short_level_pin_open_i [*2] |-> gates_any == '0 && !fault_n_o)
    else $error("open pin not handled");
  a_run_low_off: assert property (low_q >= ENA_OFF_CYC |-> gates_any == '0)
    else $error("gate on after run low");
  a_run_low_fault: assert property (low_q >= ENA_OFF_CYC |-> !fault_n_o)
    else $error("fault released while run low");
  a_over_fault: assert property (ov_q > OV_FILT_CYC + 2 |-> !fault_n_o)
    else $error("overvoltage not flagged");
  a_under_fault: assert property (uv_q > UV_FILT_CYC + 2 |-> !fault_n_o)
    else $error("undervoltage not flagged");
endmodule
bind bdfm_fault_monitor bdfm_fault_monitor_chk #(.PHASES(PHASES)) bdfm_fault_monitor_chk_inst (.*);
`default_nettype wire

// >>> verif/bdfm_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
module bdfm_mcu_model
  import bdfm_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic fault_n_i,
  output logic      run_o
);
  logic fault_at_rise = 1'b1;
  initial run_o = 1'b0;
  // low for n cycles, then high long enough for the error logic to arm
  task automatic cycle_run(input int n);
    @(negedge clk_i);
    run_o = 1'b0;
    repeat (n) @(negedge clk_i);
    fault_at_rise = fault_n_i;
    run_o = 1'b1;
    repeat (RST1_CYC + 20) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import bdfm_pkg::*;
;
  localparam int DB = 350;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic [1:0] hs_cmd = 2'h0, hs_ov = 2'h0, ov = 2'h0, ls_cmd = 2'h0, ls_ov = 2'h0;
  logic       open_pin = 1'b0, uv = 1'b0;
  wire logic       run, flt_n, lock, reg_en;
  wire logic [1:0] hs_g, ls_g;
  wire logic [1:0] st = {lock, flt_n};
  int mismatches = 0;
  int num_checks = 0;
  always #2 clk_i = ~clk_i;
  bdfm_fault_monitor #(.PHASES(2), .GL_START(50)) bdfm_fault_monitor_inst (
    .clk_i(clk_i), .reset_i(reset_i), .run_input_i(run), .hs_cmd_i(hs_cmd),
    .ls_cmd_i(ls_cmd), .hs_over_level_i(hs_ov), .ls_over_level_i(ls_ov),
    .short_level_pin_open_i(open_pin), .supply_over_i(ov[0]),
    .drain_high_sense_over_i(ov[1]), .supply_under_i(uv), .hs_gate_o(hs_g),
    .low_side_gate_out_o(ls_g), .fault_n_o(flt_n), .supply_low_lockout_o(lock),
    .regulator_en_o(reg_en));
  bdfm_mcu_model bdfm_mcu_model_inst (.clk_i(clk_i), .fault_n_i(flt_n), .run_o(run));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [1:0] s, logic [1:0] e);
    num_checks++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      mismatches++;
    end
  endtask
  task automatic w(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic t_short();
    hs_cmd = 2'h1;
    hs_ov = 2'h1;
    w(DB + 600);
    chk("status", st, 2'h1);
    w(530);
    chk("status", st, 2'h0);
    chk("gates", hs_g | ls_g, 2'h0);
    hs_ov = 2'h0;
    bdfm_mcu_model_inst.cycle_run(300);
    chk("status", st, 2'h0);
    fork
      bdfm_mcu_model_inst.cycle_run(800);
      begin
        w(752);
        chk("gates", hs_g | ls_g, 2'h0);
      end
    join
    chk("fault seen", {1'b0, bdfm_mcu_model_inst.fault_at_rise}, 2'h0);
    chk("status", st, 2'h1);
    chk("hs", hs_g, 2'h1);
  endtask
  task automatic t_down();
    hs_ov = 2'h1;
    w(500);
    hs_ov = 2'h0;
    w(500);
    hs_ov = 2'h1;
    w(500);
    hs_cmd = 2'h0;
    w(500);
    hs_cmd = 2'h1;
    w(DB + 500);
    hs_ov = 2'h0;
    chk("status", st, 2'h1);
  endtask
  task automatic t_shared();
    hs_cmd = 2'h3;
    ls_cmd = 2'h2;
    w(DB + 10);
    hs_ov = 2'h2;
    w(500);
    hs_ov = 2'h0;
    ls_ov = 2'h2;
    w(500);
    chk("status", st, 2'h0);
    ls_ov = 2'h0;
    hs_cmd = 2'h1;
    ls_cmd = 2'h0;
    bdfm_mcu_model_inst.cycle_run(400);
    chk("status", st, 2'h1);
  endtask
  task automatic t_warn();
    for (int i = 0; i < 2; i++) begin
      ov = 2'h1 << i;
      w(200);
      chk("status", st, 2'h1);
      w(100);
      chk("status", st, 2'h0);
      chk("hs", hs_g, 2'h1);
      ov = 2'h0;
      w(5);
      chk("status", st, 2'h1);
    end
    open_pin = 1'b1;
    w(5);
    chk("gates", hs_g | ls_g, 2'h0);
    chk("status", st, 2'h0);
    open_pin = 1'b0;
    w(5);
    chk("status", st, 2'h1);
  endtask
  task automatic t_under();
    uv = 1'b1;
    w(300);
    chk("status", st, 2'h2);
    chk("reg", {1'b0, reg_en}, 2'h0);
    chk("gates", hs_g | ls_g, 2'h0);
    uv = 1'b0;
    w(50);
    chk("gates", hs_g | ls_g, 2'h0);
    bdfm_mcu_model_inst.cycle_run(800);
    chk("status", st, 2'h1);
    chk("hs", hs_g, 2'h1);
  endtask
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    w(2);
    reset_i = 1'b0;
    bdfm_mcu_model_inst.cycle_run(1);
    chk("ls", ls_g, 2'h3);
    chk("status", st, 2'h1);
    t_short();
    t_down();
    t_shared();
    t_warn();
    t_under();
    summarize();
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
